// ### verilog/fpi_params.svh
/*
  Constants of the coprocessor intake: instruction fields, operand word
  layout, scratchpad fields and reset values.
  Assumes inclusion before the package and the intake module.
*/
`ifndef FPI_PARAMS_SVH
`define FPI_PARAMS_SVH

`define FPI_OPC_HI     15
`define FPI_OPC_LO     12
`define FPI_OPC_FP     4'hf
`define FPI_STORE_BIT  11
`define FPI_FMT_HI     7
`define FPI_FMT_LO     6
`define FPI_AC_HI      2
`define FPI_AC_LO      0
`define FPI_AC_MAX     3'h5
`define FPI_IR_RST     16'h0000
`define FPI_WORD_RST   16'h0000
`define FPI_BYTE_ZERO  8'h00
`define FPI_EXP_RST    8'h00
`define FPI_ENTRIES    16
`define FPI_ENT_LOAD   4'h6
`define FPI_ENT_ZERO   4'hf
`define FPI_CNT_RST    2'h0
`define FPI_CNT_STEP   2'h1
`define FPI_CNT_W1     2'h1
`define FPI_CNT_W3     2'h3
`define FPI_LAST_I     2'h0
`define FPI_LAST_LF    2'h1
`define FPI_LAST_D     2'h3
`define FPI_SIGN_BIT   15
`define FPI_EXP_HI     14
`define FPI_EXP_LO     7
`define FPI_FRAC7_HI   6
`define FPI_ST_HI      15
`define FPI_ST_LO      8
`define FPI_Q_SHIFT_HI 30
`define FPI_OVF_LOAD   1'h0
`define FPI_HIDDEN     1'h1
`define FPI_GUARD_ZERO 3'h0
`define FPI_D_ZERO     19'h00000
`define FPI_HI_ZERO    25'h0000000
`define FPI_LO_ZERO    35'h000000000
`define FPI_OVF_BIT    59
`define FPI_FA_HI      58
`define FPI_FA_LO      51
`define FPI_FB_HI      50
`define FPI_FB_LO      35
`define FPI_FC_HI      34
`define FPI_FC_LO      19
`define FPI_FD_HI      18
`define FPI_FD_LO      3
`define FPI_BUS_HI     58
`define FPI_BUS_LO     3

`endif

// ### verilog/fpi_pkg.sv
/*
  Types of the coprocessor intake: sequencer states, operand formats and
  scratchpad load kinds.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package fpi_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_DECODE = 3'h1,
    ST_LOAD   = 3'h2,
    ST_STORE  = 3'h3,
    ST_DONE   = 3'h4
  } fpi_state_e;
  typedef enum logic [1:0] {
    FMT_I = 2'h0,
    FMT_L = 2'h1,
    FMT_F = 2'h2,
    FMT_D = 2'h3
  } fpi_fmt_e;
  typedef enum logic [1:0] {
    WR_NONE = 2'h0,
    WR_HI   = 2'h1,
    WR_LO32 = 2'h2,
    WR_I16  = 2'h3
  } fpi_wr_e;
endpackage
`default_nettype wire

// ### verilog/fpi_intake.sv
/*
  Instruction and operand intake of a floating-point coprocessor: shadow
  instruction registers, input mux, input buffers and fraction scratchpad.
  Assumes the host CPU on the same clock, driving all strobes synchronously.
*/
// Summary of operation
// - Opcode with top four bits set is a floating-point instruction.
// - Every instruction loaded by the CPU is also captured here.
// - Executing register loads only when idle and instruction not aborted.
// - Executing instruction is decoded; floating ones start their sequence.
// - Load class waits for operands, completes as the scratchpad is written.
// - Next floating instruction waits until the current one finishes.
// - Store class executes at once, then drives result onto input bus.
// - Input mux picks fetch lines or CPU output lines.
// - Double words one and two give sign, exponent, fraction bits 57-35.
// - Double words three and four go to fraction bits 34-03.
// - Single operand loads like first two words of a double.
// - Long integer halves go to buffers, then scratchpad bits 34-03.
// - Short integer goes to high buffer, then scratchpad bits 34-19.
// - Quotient bits shift left into buffers, then go to an accumulator.
// - Status high byte lands right-justified in low buffer, upper zero.
// - Scratchpad holds sixteen 60-bit words, written from ALU and muxes.
// - Word fields: overflow, A, B, C, D and guard bits.
// - Entries numbered 0 to 17 octal; only 0-5 visible to programs.
// - Operands and results travel on a 56-bit internal bus.
// - Fetched register loads only while the load enable is low.
// - Attention is raised when the coprocessor is ready to proceed.
`include "fpi_params.svh"
`default_nettype none
module fpi_intake
  import fpi_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        instr_load_enable_n_in,
  input  wire logic [15:0] cpu_fetch_data_lines_in,
  input  wire logic [15:0] cpu_output_data_lines_in,
  input  wire logic        operand_via_output_in,
  input  wire logic        status_load_in,
  input  wire logic        op_word_valid_in,
  input  wire logic        coproc_select_in,
  input  wire logic        cpu_abort_strobe_in,
  input  wire logic        coproc_init_in,
  input  wire logic        quot_shift_in,
  input  wire logic        quot_bit_in,
  input  wire logic        quot_done_in,
  input  wire logic        alu_wr_in,
  input  wire logic [3:0]  alu_wr_idx_in,
  input  wire logic [59:0] alu_result_in,
  input  wire logic [3:0]  scratch_rd_idx_in,
  output logic [15:0]      fetched_instr_out,
  output logic [15:0]      executing_instr_out,
  output logic             coproc_busy_out,
  output logic             coproc_attention_out,
  output logic [15:0]      cpu_input_bus_out,
  output logic             cpu_input_bus_oe_out,
  output logic             sign_hold_out,
  output logic [7:0]       exponent_hold_out,
  output logic [59:0]      scratch_rd_data_out,
  output logic [55:0]      internal_fraction_bus_out
);

  ////////////////////////////////////////////////////////////////////////
  // Decode functions
  function automatic logic is_fp(input logic [15:0] ir);
    is_fp = ir[`FPI_OPC_HI:`FPI_OPC_LO] == `FPI_OPC_FP;
  endfunction
  function automatic logic [1:0] last_idx(input fpi_fmt_e f);
    unique case (f)
      FMT_I:   last_idx = `FPI_LAST_I;
      FMT_D:   last_idx = `FPI_LAST_D;
      default: last_idx = `FPI_LAST_LF;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  fpi_state_e  state_q, state_d;
  fpi_wr_e     wr_q, wr_d, word_wr;
  logic        fin_q, fin_d;
  logic [1:0]  cnt_q, cnt_d;
  logic        pend_q;
  logic [15:0] fetched_q, exec_q;
  logic [15:0] buf_hi_q, buf_hi_d, buf_lo_q, buf_lo_d;
  logic        sign_q;
  logic [7:0]  exp_q;
  logic [15:0] result_q;
  logic [59:0] sp_q [`FPI_ENTRIES];
  logic [59:0] rd_q;
  logic [55:0] bus_q;
  logic [3:0]  sp_idx;
  logic        we_hi, we_lo;
  logic [59:0] wr_word;

  ////////////////////////////////////////////////////////////////////////
  // Decoding and selection
  wire        sel_out   = status_load_in | operand_via_output_in;
  wire [15:0] in_word   = sel_out ? cpu_output_data_lines_in
                                  : cpu_fetch_data_lines_in;
  wire        abort     = cpu_abort_strobe_in & coproc_select_in;
  wire        init      = coproc_init_in & coproc_select_in;
  wire        ld_fetch  = !instr_load_enable_n_in;
  wire        take      = state_q == ST_IDLE && pend_q && !abort;
  wire        exec_fp   = is_fp(exec_q);
  wire        exec_st   = exec_q[`FPI_STORE_BIT];
  wire [2:0]  ac        = exec_q[`FPI_AC_HI:`FPI_AC_LO];
  wire        ac_vis    = ac <= `FPI_AC_MAX;
  wire [3:0]  tgt       = ac_vis ? {1'h0, ac} : `FPI_ENT_LOAD;
  fpi_fmt_e   fmt;
  assign fmt = fpi_fmt_e'(exec_q[`FPI_FMT_HI:`FPI_FMT_LO]);
  wire        word_in   = state_q == ST_LOAD && op_word_valid_in;
  wire        last_word = cnt_q == last_idx(fmt);
  wire        float_fmt = fmt == FMT_F || fmt == FMT_D;
  wire        hold_se   = word_in && cnt_q == `FPI_CNT_W1 && float_fmt;
  wire [31:0] quot_cat  = {buf_hi_q, buf_lo_q};
  assign word_wr = (fmt == FMT_I) ? WR_I16 :
                   (cnt_q == `FPI_CNT_W1) ?
                     ((fmt == FMT_L) ? WR_LO32 : WR_HI) :
                   (cnt_q == `FPI_CNT_W3) ? WR_LO32 : WR_NONE;
  // Scratchpad load words built from the input buffers
  wire [59:0] ld_hi_word = {`FPI_OVF_LOAD, `FPI_HIDDEN,
                            buf_hi_q[`FPI_FRAC7_HI:0], buf_lo_q, `FPI_LO_ZERO};
  wire [59:0] ld_lo_word = {`FPI_HI_ZERO, buf_hi_q, buf_lo_q, `FPI_GUARD_ZERO};
  wire [59:0] ld_i_word  = {`FPI_HI_ZERO, buf_hi_q, `FPI_D_ZERO};

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    wr_d    = WR_NONE;
    fin_d   = 1'h0;
    unique case (state_q)
      ST_IDLE: begin
        if (take) state_d = ST_DECODE;
      end
      ST_DECODE: begin
        cnt_d = `FPI_CNT_RST;
        if (!exec_fp) state_d = ST_IDLE;
        else if (exec_st) state_d = ST_STORE;
        else state_d = ST_LOAD;
      end
      ST_LOAD: begin
        if (op_word_valid_in) begin
          cnt_d = 2'(cnt_q + `FPI_CNT_STEP);
          wr_d  = word_wr;
          fin_d = last_word;
        end
        if (wr_q != WR_NONE && fin_q) state_d = ST_DONE;
      end
      ST_STORE: state_d = ST_DONE;
      ST_DONE:  state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
    if (abort || init) begin
      state_d = ST_IDLE;
      wr_d    = WR_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input buffer next values
  always_comb begin
    buf_hi_d = buf_hi_q;
    buf_lo_d = buf_lo_q;
    if (status_load_in) begin
      buf_lo_d = {`FPI_BYTE_ZERO, in_word[`FPI_ST_HI:`FPI_ST_LO]};
    end else if (quot_shift_in) begin
      {buf_hi_d, buf_lo_d} = {quot_cat[`FPI_Q_SHIFT_HI:0], quot_bit_in};
    end else if (word_in) begin
      if (cnt_q[0]) buf_lo_d = in_word;
      else buf_hi_d = in_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scratchpad write selection
  always_comb begin
    sp_idx  = alu_wr_idx_in;
    we_hi   = alu_wr_in;
    we_lo   = alu_wr_in;
    wr_word = alu_result_in;
    if (wr_q != WR_NONE || quot_done_in) begin
      sp_idx = tgt;
      we_hi  = wr_q == WR_HI;
      we_lo  = wr_q != WR_HI;
      unique case (wr_q)
        WR_HI:   wr_word = ld_hi_word;
        WR_I16:  wr_word = ld_i_word;
        default: wr_word = ld_lo_word;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      wr_q    <= WR_NONE;
      fin_q   <= 1'h0;
      cnt_q   <= `FPI_CNT_RST;
    end else begin
      state_q <= state_d;
      wr_q    <= wr_d;
      fin_q   <= fin_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || init) begin
      fetched_q <= `FPI_IR_RST;
      exec_q    <= `FPI_IR_RST;
      pend_q    <= 1'h0;
    end else begin
      if (ld_fetch) fetched_q <= cpu_fetch_data_lines_in;
      if (take) exec_q <= fetched_q;
      if (ld_fetch) pend_q <= 1'h1;
      else if (take || abort) pend_q <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || init) begin
      buf_hi_q <= `FPI_WORD_RST;
      buf_lo_q <= `FPI_WORD_RST;
      sign_q   <= 1'h0;
      exp_q    <= `FPI_EXP_RST;
      result_q <= `FPI_WORD_RST;
    end else begin
      buf_hi_q <= buf_hi_d;
      buf_lo_q <= buf_lo_d;
      if (hold_se) begin
        sign_q <= buf_hi_q[`FPI_SIGN_BIT];
        exp_q  <= buf_hi_q[`FPI_EXP_HI:`FPI_EXP_LO];
      end
      if (state_q == ST_STORE) result_q <= sp_q[tgt][`FPI_FB_HI:`FPI_FB_LO];
    end
  end

  // Scratchpad; the top entry stays zero as a constant source
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < `FPI_ENTRIES; i++) begin
      if (!rst_n_in) begin
        sp_q[i] <= '0;
      end else if (4'(i) == sp_idx && sp_idx != `FPI_ENT_ZERO) begin
        if (we_hi) sp_q[i][`FPI_OVF_BIT:`FPI_FB_LO] <=
          wr_word[`FPI_OVF_BIT:`FPI_FB_LO];
        if (we_lo) sp_q[i][`FPI_FC_HI:0] <= wr_word[`FPI_FC_HI:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rd_q  <= '0;
      bus_q <= '0;
    end else begin
      rd_q  <= sp_q[scratch_rd_idx_in];
      bus_q <= sp_q[scratch_rd_idx_in][`FPI_BUS_HI:`FPI_BUS_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign fetched_instr_out         = fetched_q;
  assign executing_instr_out       = exec_q;
  assign coproc_busy_out           = state_q != ST_IDLE;
  assign coproc_attention_out      = state_q == ST_DONE;
  assign cpu_input_bus_oe_out      = state_q == ST_DONE && exec_st;
  assign cpu_input_bus_out         = result_q;
  assign sign_hold_out             = sign_q;
  assign exponent_hold_out         = exp_q;
  assign scratch_rd_data_out       = rd_q;
  assign internal_fraction_bus_out = bus_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_store_out;
    cpu_input_bus_oe_out && coproc_attention_out ##1 state_q == ST_IDLE;
  endsequence
  property p_fp_start;
    state_q == ST_DECODE && exec_fp && !abort && !init |=> state_q inside {ST_LOAD, ST_STORE};
  endproperty
  a_fp_start: assert property (p_fp_start) else $error("fp decode no start");
  property p_nonfp_idle;
    state_q == ST_DECODE && !exec_fp |=> state_q == ST_IDLE;
  endproperty
  a_nonfp_idle: assert property (p_nonfp_idle) else $error("non-fp not dropped");
  property p_fetch_cap;
    ld_fetch && !init |=> fetched_q == $past(cpu_fetch_data_lines_in);
  endproperty
  a_fetch_cap: assert property (p_fetch_cap) else $error("fetch not captured");
  property p_fetch_hold;
    !ld_fetch && !init |=> $stable(fetched_q);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch reg moved");
  property p_exec_hold;
    state_q != ST_IDLE && !init |=> $stable(exec_q);
  endproperty
  a_exec_hold: assert property (p_exec_hold) else $error("exec reg moved busy");
  property p_abort;
    abort && !init |=> state_q == ST_IDLE && $stable(exec_q);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not honoured");
  property p_store;
    state_q == ST_STORE && !abort && !init |=> s_store_out;
  endproperty
  a_store: assert property (p_store) else $error("store result missing");
  property p_status;
    status_load_in && !init |=> buf_lo_q ==
      {`FPI_BYTE_ZERO, $past(cpu_output_data_lines_in[`FPI_ST_HI:`FPI_ST_LO])};
  endproperty
  a_status: assert property (p_status) else $error("status byte misplaced");
  property p_quot;
    quot_shift_in && !status_load_in && !init |=> buf_lo_q[0] == $past(quot_bit_in)
      && buf_hi_q[0] == $past(buf_lo_q[`FPI_SIGN_BIT]);
  endproperty
  a_quot: assert property (p_quot) else $error("quotient shift wrong");
  property p_sign_exp;
    hold_se && !init |=> sign_hold_out == $past(buf_hi_q[`FPI_SIGN_BIT])
      && exponent_hold_out == $past(buf_hi_q[`FPI_EXP_HI:`FPI_EXP_LO]);
  endproperty
  a_sign_exp: assert property (p_sign_exp) else $error("sign not held");
  property p_init;
    init |=> fetched_q == `FPI_IR_RST && exec_q == `FPI_IR_RST;
  endproperty
  a_init: assert property (p_init) else $error("init did not clear");

endmodule
`default_nettype wire

// ### tb/fpi_host_model.sv
/*
  Host CPU side of the coprocessor intake: instruction fetch, operand
  delivery and status byte transfer, all driven on the falling clock edge.
  Assumes the intake shares the same clock and samples on the rising edge.
*/
`default_nettype none
module fpi_host_model (
  input  wire logic        clk_in,
  output logic             load_en_n_out,
  output logic [15:0]      fetch_out,
  output logic [15:0]      dout_out,
  output logic             via_out,
  output logic             status_load_out,
  output logic             word_valid_out
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////
  initial begin
    load_en_n_out = 1'b1;
    fetch_out = 16'h0000;
    dout_out = 16'h0000;
    via_out = 1'b0;
    status_load_out = 1'b0;
    word_valid_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Coprocessor assumed present: every instruction goes to it
  // One load enable cycle per fetch, refetch after abort
  task automatic fetch(input logic [15:0] w);
    @(negedge clk_in);
    load_en_n_out = 1'b0;
    fetch_out = w;
    @(negedge clk_in);
    load_en_n_out = 1'b1;
    fetch_out = ~w;
  endtask

  // Operand words back to back on chosen lines
  task automatic send(input logic [15:0] ws [4], input int n, input logic via);
    for (int k = 0; k < n; k++) begin
      @(negedge clk_in);
      word_valid_out = 1'b1;
      via_out = via;
      if (via) dout_out = ws[k];
      else fetch_out = ws[k];
    end
    @(negedge clk_in);
    word_valid_out = 1'b0;
    via_out = 1'b0;
    fetch_out = ~fetch_out;
    dout_out = ~dout_out;
  endtask

  // Status word on output lines with load pulse
  task automatic status(input logic [15:0] d);
    @(negedge clk_in);
    dout_out = d;
    status_load_out = 1'b1;
    @(negedge clk_in);
    status_load_out = 1'b0;
    dout_out = ~d;
  endtask
endmodule
`default_nettype wire

// ### tb/fpi_intake_test.sv
/*
  Self-checking bench of the coprocessor intake with random operands.
  Assumes the intake package and the host model are compiled first.
*/
`default_nettype none
module fpi_intake_test
  import fpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        ref_clk, rst_n, load_en_n, via, status_load, word_valid;
  logic        sel, abort, init, q_shift, q_bit, q_done, alu_wr;
  logic        busy, att, oe, sign_h, last_oe;
  logic [15:0] fetch_lines, dout_lines, fetched, executing, in_bus, last_bus;
  logic [3:0]  alu_idx, rd_idx;
  logic [59:0] alu_res, rd_data, model;
  logic [7:0]  exp_h;
  logic [55:0] fbus;
  logic [31:0] seed = 32'h9b7bcc25;
  logic [2:0]  ac;
  logic [15:0] ins_a, ins_b;
  int          fails = 0;
  int          n_checks = 0;

  fpi_host_model host (.clk_in(ref_clk), .load_en_n_out(load_en_n),
    .fetch_out(fetch_lines), .dout_out(dout_lines), .via_out(via),
    .status_load_out(status_load), .word_valid_out(word_valid));

  fpi_intake DUT (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .instr_load_enable_n_in(load_en_n),
    .cpu_fetch_data_lines_in(fetch_lines), .cpu_output_data_lines_in(dout_lines),
    .operand_via_output_in(via), .status_load_in(status_load),
    .op_word_valid_in(word_valid), .coproc_select_in(sel), .cpu_abort_strobe_in(abort),
    .coproc_init_in(init), .quot_shift_in(q_shift), .quot_bit_in(q_bit),
    .quot_done_in(q_done), .alu_wr_in(alu_wr), .alu_wr_idx_in(alu_idx),
    .alu_result_in(alu_res), .scratch_rd_idx_in(rd_idx), .fetched_instr_out(fetched),
    .executing_instr_out(executing), .coproc_busy_out(busy), .coproc_attention_out(att),
    .cpu_input_bus_out(in_bus), .cpu_input_bus_oe_out(oe), .sign_hold_out(sign_h),
    .exponent_hold_out(exp_h), .scratch_rd_data_out(rd_data),
    .internal_fraction_bus_out(fbus));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic results();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a flag, sampled at falling edges
  task automatic wait_for(input bit want_att);
    int i;
    i = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (((want_att ? att : busy) !== 1'b1) && i < 64);
    if (i >= 64) begin
      fails++;
      results();
    end
    last_oe = oe;
    last_bus = in_bus;
  endtask

  task automatic rd(input logic [3:0] i);
    @(negedge ref_clk);
    rd_idx = i;
    @(negedge ref_clk);
  endtask

  // Load one operand of a format into the entry for ac (six above five) and track the expected word
  task automatic run_load(input fpi_fmt_e f, input logic via_sel);
    logic [15:0] ws [4];
    logic [31:0] r;
    r = rnd();
    for (int k = 0; k < 4; k++) ws[k] = 16'(rnd());
    host.fetch({4'hf, 1'b0, r[2:0], f, r[5:3], ac});
    wait_for(1'b0);
    host.send(ws, (f == FMT_I) ? 1 : (f == FMT_D) ? 4 : 2, via_sel);
    wait_for(1'b1);
    case (f)
      FMT_I: model[34:0] = {ws[0], 19'h00000};
      FMT_L: model[34:0] = {ws[0], ws[1], 3'h0};
      FMT_F: model[59:35] = {2'h1, ws[0][6:0], ws[1]};
      default: model = {2'h1, ws[0][6:0], ws[1], ws[2], ws[3], 3'h0};
    endcase
    if (f == FMT_F || f == FMT_D) begin
      chk(64'(sign_h), 64'(ws[0][15]));
      chk(64'(exp_h), 64'(ws[0][14:7]));
    end
    chk(64'(last_oe), 64'h0);
    rd((ac > 3'h5) ? 4'h6 : {1'b0, ac});
    chk(64'(rd_data), 64'(model));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic [15:0] d;
    {rst_n, sel, abort, init, q_shift, q_bit, q_done, alu_wr} = 8'h00;
    alu_idx = 4'h0;
    rd_idx = 4'h0;
    alu_res = 60'h0;
    model = 60'h0;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    chk(64'({fetched, executing, busy}), 64'h0);
    // Non-floating instructions, one at the opcode boundary
    for (int k = 0; k < 2; k++) begin
      ins_a = (k == 0) ? (16'he000 | 16'(rnd() & 32'h0fff)) : 16'(rnd() & 32'h7fff);
      host.fetch(ins_a);
      repeat (3) @(negedge ref_clk);
      chk(64'(fetched), 64'(ins_a));
      chk(64'(executing), 64'(ins_a));
      chk(64'(busy), 64'h0);
    end
    ac = 3'(rnd() % 6);
    run_load(FMT_I, 1'b0);
    run_load(FMT_L, 1'b1);
    run_load(FMT_F, 1'b0);
    run_load(FMT_D, 1'b0);
    // Second floating instruction while busy, then abort
    ins_a = {4'hf, 1'b0, 3'h0, FMT_I, 3'h0, ac};
    ins_b = {4'hf, 1'b1, 3'h2, FMT_F, 3'h5, ac};
    host.fetch(ins_a);
    wait_for(1'b0);
    host.fetch(ins_b);
    repeat (2) @(negedge ref_clk);
    chk(64'(executing), 64'(ins_a));
    chk(64'(fetched), 64'(ins_b));
    sel = 1'b1;
    abort = 1'b1;
    @(negedge ref_clk);
    {sel, abort} = 2'h0;
    repeat (3) @(negedge ref_clk);
    chk(64'(busy), 64'h0);
    chk(64'(executing), 64'(ins_a));
    host.fetch(ins_b);
    wait_for(1'b1);
    chk(64'(executing), 64'(ins_b));
    chk(64'({last_oe, last_bus}), 64'({1'b1, model[50:35]}));
    // Quotient shifted in, then status byte in low buffer
    q = rnd();
    for (int k = 31; k >= 0; k--) begin
      @(negedge ref_clk);
      q_shift = 1'b1;
      q_bit = q[k];
    end
    @(negedge ref_clk);
    q_shift = 1'b0;
    q_done = 1'b1;
    @(negedge ref_clk);
    q_done = 1'b0;
    model[34:0] = {q, 3'h0};
    rd({1'b0, ac});
    chk(64'(rd_data), 64'(model));
    d = 16'(rnd());
    host.status(d);
    q_done = 1'b1;
    @(negedge ref_clk);
    q_done = 1'b0;
    model[18:3] = {8'h00, d[15:8]};
    rd({1'b0, ac});
    chk(64'(rd_data), 64'(model));
    // Full-word writes, including the hard-wired zero entry
    for (int k = 0; k < 2; k++) begin
      @(negedge ref_clk);
      alu_wr = 1'b1;
      alu_idx = (k == 0) ? 4'h8 : 4'hf;
      alu_res = 60'({rnd(), rnd()});
      @(negedge ref_clk);
      alu_wr = 1'b0;
      rd(alu_idx);
      chk(64'(rd_data), (k == 0) ? 64'(alu_res) : 64'h0);
      chk(64'(fbus), (k == 0) ? 64'(alu_res[58:3]) : 64'h0);
    end
    // Accumulator code above the visible range lands in entry six
    ac = 3'h7;
    model = 60'h0;
    run_load(FMT_I, 1'b0);
    sel = 1'b1;
    init = 1'b1;
    @(negedge ref_clk);
    {sel, init} = 2'h0;
    @(negedge ref_clk);
    chk(64'({fetched, executing}), 64'h0);
    results();
  end
endmodule
`default_nettype wire
